// File: hw/frio_consts.svh
// constants for the fieldbus remote point map block
`ifndef FRIO_CONSTS_SVH
`define FRIO_CONSTS_SVH
// ***********************
// timing
// ***********************
`define FRIO_CLK_MHZ 200
`define FRIO_INIT_NS 1000
`define FRIO_INIT_CYC ((`FRIO_INIT_NS * `FRIO_CLK_MHZ + 999) / 1000)
// ***********************
// point space
// ***********************
`define FRIO_WORD_BITS 16
`define FRIO_WORDS 6
`define FRIO_STATION_STRIDE 2
`define FRIO_ROBOT_BIT_BASE 512
`define FRIO_LINK_READY_BIT 91
`define FRIO_STATUS_POINTS 31
`define FRIO_CMD_POINTS 12
// ***********************
// register offsets
// ***********************
`define FRIO_CTRL_OFS 8'h00
`define FRIO_CONFIG_OFS 8'h04
`define FRIO_STATUS_OFS 8'h08
`define FRIO_IRQ_STATUS_OFS 8'h0c
`define FRIO_IRQ_CLEAR_OFS 8'h10
`define FRIO_IRQ_ENABLE_OFS 8'h14
`define FRIO_USER_IN_OFS 8'h20
`define FRIO_OUT_WORD_OFS 8'h40
// ***********************
// field positions and reset values
// ***********************
`define FRIO_CTRL_APPLY_BIT 0
`define FRIO_CFG_STATION_LSB 0
`define FRIO_CFG_IN_BYTES_LSB 8
`define FRIO_CFG_OUT_BYTES_LSB 16
`define FRIO_CFG_ALLOC_BIT 24
`define FRIO_STS_N_LSB 8
`define FRIO_STS_IN_LAST_LSB 16
`define FRIO_IRQ_READY_BIT 0
`define FRIO_IRQ_WRITE_BIT 1
`define FRIO_IRQ_MISS_BIT 2
`define FRIO_RST_STATION 3'h1
`define FRIO_RST_BYTES 6'h20
`endif

// File: hw/frio_pkg.sv
// types shared by the fieldbus remote point map block
package frio_pkg;
  // robot status presented to the master when remote control is allocated
  typedef struct packed {
    logic command_failed;
    logic command_in_progress;
    logic [13:0] fault_number;
    logic teaching_operation;
    logic automatic_operation;
    logic [2:0] active_program;
    logic at_rest_position;
    logic drive_power_active;
    logic warning;
    logic severe_fault;
    logic guard_open;
    logic emergency_halt_active;
    logic error;
    logic paused;
    logic running;
    logic ready;
  } frio_robot_status_t;
  // commands decoded from the master's output points
  typedef struct packed {
    logic shutdown;
    logic home;
    logic drive_power_off_request;
    logic drive_power_on_request;
    logic reset;
    logic resume;
    logic pause;
    logic stop;
    logic [2:0] program_choice;
    logic start;
  } frio_remote_cmd_t;
  // word access from the fieldbus master
  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] word;
    logic [15:0] wdata;
  } frio_link_req_t;
  typedef struct packed {
    logic ack;
    logic hit;
    logic [15:0] rdata;
  } frio_link_rsp_t;
  typedef enum logic [0:0] {FRIO_INIT, FRIO_RUN} frio_state_t;
endpackage

// File: hw/frio_map.sv
// fieldbus remote point map: robot status to remote inputs, master outputs to commands
// ***********************
// ***********************
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "frio_consts.svh"
module frio_map #(
  parameter int WORDS = `FRIO_WORDS,
  parameter int INIT_CYC = `FRIO_INIT_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // robot side
  input wire frio_pkg::frio_robot_status_t robot_status,
  output frio_pkg::frio_remote_cmd_t remote_cmd,
  // fieldbus master word access
  input wire frio_pkg::frio_link_req_t link_req,
  output frio_pkg::frio_link_rsp_t link_rsp,
  // point space as seen by the master
  output logic [WORDS*16-1:0] remote_in_point,
  output logic [WORDS*16-1:0] remote_out_point,
  // status
  output logic link_ready,
  output logic irq
);
  import frio_pkg::*;
  localparam int PTS = WORDS * 16;

  // ***********************
  // state
  // ***********************
  frio_state_t state;
  logic [15:0] init_cnt;
  logic [2:0] cfg_station;
  logic [5:0] cfg_in_bytes;
  logic [5:0] cfg_out_bytes;
  logic cfg_alloc;
  logic [2:0] act_station;
  logic [5:0] act_in_bytes;
  logic [5:0] act_out_bytes;
  logic act_alloc;
  logic [15:0] user_in [WORDS];
  logic [15:0] out_word [WORDS];
  logic [2:0] irq_sts;
  logic [2:0] irq_en;
  logic [31:0] rd_q;
  logic err_q;

  // ***********************
  // apb decode
  // ***********************
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite;
  wire [7:0] wofs = paddr - `FRIO_USER_IN_OFS;
  wire [7:0] oofs = paddr - `FRIO_OUT_WORD_OFS;
  wire hit_user = paddr >= `FRIO_USER_IN_OFS && wofs[7:2] < 6'(WORDS) && paddr[1:0] == 2'h0;
  wire hit_out = paddr >= `FRIO_OUT_WORD_OFS && oofs[7:2] < 6'(WORDS) && paddr[1:0] == 2'h0;
  wire hit_ctrl = paddr == `FRIO_CTRL_OFS;
  wire hit_cfg = paddr == `FRIO_CONFIG_OFS;
  wire hit_sts = paddr == `FRIO_STATUS_OFS;
  wire hit_isr = paddr == `FRIO_IRQ_STATUS_OFS;
  wire hit_icl = paddr == `FRIO_IRQ_CLEAR_OFS;
  wire hit_ien = paddr == `FRIO_IRQ_ENABLE_OFS;
  wire mapped = hit_user | hit_out | hit_ctrl | hit_cfg | hit_sts | hit_isr | hit_icl | hit_ien;
  wire apply = wr_acc && hit_ctrl && pwdata[`FRIO_CTRL_APPLY_BIT];

  // base word index and range checks
  wire [7:0] base_n = 8'((act_station - 3'h1) * `FRIO_STATION_STRIDE);
  wire [7:0] rel_word = link_req.word - base_n;
  wire link_hit = link_req.word >= base_n && rel_word < 8'(WORDS);
  wire link_take = link_req.req && state == FRIO_RUN;
  wire link_wr_hit = link_take && link_req.we && link_hit;
  wire [9:0] in_last = 10'(`FRIO_ROBOT_BIT_BASE + 8 * act_in_bytes - 1);

  // ***********************
  // point assembly
  // ***********************
  logic [PTS-1:0] user_flat;
  logic [PTS-1:0] out_flat;
  logic [PTS-1:0] in_mask;
  logic [PTS-1:0] out_mask;
  logic [PTS-1:0] next_in_point;
  genvar gi;
  // per-bit flatten and size masks; bits past the configured bytes read zero except the link ready point
  generate
    for (gi = 0; gi < PTS; gi++) begin : g_pt
      assign user_flat[gi] = user_in[gi / 16][gi % 16];
      assign out_flat[gi] = out_word[gi / 16][gi % 16];
      assign in_mask[gi] = 10'(gi) < 10'(8 * act_in_bytes);
      assign out_mask[gi] = 10'(gi) < 10'(8 * act_out_bytes);
    end
  endgenerate

  // status occupies the low points only when allocated; link ready overrides everything
  wire [PTS-1:0] alloc_view = {user_flat[PTS-1:`FRIO_STATUS_POINTS], robot_status};
  wire [PTS-1:0] sel_view = act_alloc ? alloc_view : user_flat;
  always_comb begin
    next_in_point = sel_view & in_mask;
    next_in_point[`FRIO_LINK_READY_BIT] = link_ready;
  end

  // commands come from the master's points only while allocated
  wire [`FRIO_CMD_POINTS-1:0] cmd_bits = out_flat[`FRIO_CMD_POINTS-1:0];
  wire frio_remote_cmd_t next_cmd = act_alloc ? frio_remote_cmd_t'(cmd_bits) : '0;

  // ***********************
  // init and restart sequencer
  // ***********************
  // a restart drops link ready so the master never sees points under the old map
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= FRIO_INIT;
      init_cnt <= 16'h0000;
      link_ready <= 1'b0;
    end else if (apply) begin
      state <= FRIO_INIT;
      init_cnt <= 16'h0000;
      link_ready <= 1'b0;
    end else begin
      unique case (state)
        FRIO_INIT: begin
          init_cnt <= init_cnt + 16'h0001;
          if (init_cnt == 16'(INIT_CYC - 1)) begin
            state <= FRIO_RUN;
            link_ready <= 1'b1;
          end
        end
        FRIO_RUN: init_cnt <= 16'h0000;
      endcase
    end
  end

  // ***********************
  // configuration
  // ***********************
  // software edits pending values; they only take effect through a restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_station <= `FRIO_RST_STATION;
      cfg_in_bytes <= `FRIO_RST_BYTES;
      cfg_out_bytes <= `FRIO_RST_BYTES;
      cfg_alloc <= 1'b0;
    end else if (wr_acc && hit_cfg) begin
      cfg_station <= pwdata[`FRIO_CFG_STATION_LSB +: 3];
      cfg_in_bytes <= pwdata[`FRIO_CFG_IN_BYTES_LSB +: 6];
      cfg_out_bytes <= pwdata[`FRIO_CFG_OUT_BYTES_LSB +: 6];
      cfg_alloc <= pwdata[`FRIO_CFG_ALLOC_BIT];
    end
  end

  // stations 1 to 4 only; anything else falls back to station 1
  wire [2:0] station_ok = (cfg_station == 3'h0 || cfg_station > 3'h4) ? 3'h1 : cfg_station;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_station <= `FRIO_RST_STATION;
      act_in_bytes <= `FRIO_RST_BYTES;
      act_out_bytes <= `FRIO_RST_BYTES;
      act_alloc <= 1'b0;
    end else if (apply) begin
      act_station <= station_ok;
      act_in_bytes <= cfg_in_bytes;
      act_out_bytes <= cfg_out_bytes;
      act_alloc <= cfg_alloc;
    end
  end

  // ***********************
  // point words
  // ***********************
  // user input words written by software; master output words written by the link
  generate
    for (gi = 0; gi < WORDS; gi++) begin : g_word
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          user_in[gi] <= 16'h0000;
        end else if (wr_acc && hit_user && wofs[7:2] == 6'(gi)) begin
          user_in[gi] <= pwdata[15:0];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_word[gi] <= 16'h0000;
        end else if (apply) begin
          out_word[gi] <= 16'h0000;
        end else if (link_wr_hit && rel_word == 8'(gi)) begin
          out_word[gi] <= link_req.wdata & out_mask[gi*16 +: 16];
        end
      end
    end
  endgenerate

  // ***********************
  // link answer and point outputs
  // ***********************
  wire [15:0] in_word_sel = next_in_point[rel_word[2:0]*16 +: 16];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_rsp <= '0;
      remote_in_point <= '0;
      remote_out_point <= '0;
      remote_cmd <= '0;
    end else begin
      link_rsp.ack <= link_take;
      link_rsp.hit <= link_take && link_hit;
      link_rsp.rdata <= (link_take && !link_req.we && link_hit) ? in_word_sel : 16'h0000;
      remote_in_point <= next_in_point;
      remote_out_point <= out_flat;
      remote_cmd <= next_cmd;
    end
  end

  // ***********************
  // interrupts
  // ***********************
  wire [2:0] irq_evt = {link_take && !link_hit, link_wr_hit, state == FRIO_INIT && init_cnt == 16'(INIT_CYC - 1)};
  wire [2:0] irq_clr = (wr_acc && hit_icl) ? pwdata[2:0] : 3'h0;
  // an event in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts <= 3'h0;
      irq_en <= 3'h0;
    end else begin
      irq_sts <= (irq_sts & ~irq_clr) | irq_evt;
      if (wr_acc && hit_ien) begin
        irq_en <= pwdata[2:0];
      end
    end
  end
  assign irq = |(irq_sts & irq_en);

  // ***********************
  // apb read path
  // ***********************
  // read data is captured in the setup cycle, so the access phase never waits
  wire [31:0] sts_word = {6'h00, in_last, 4'h0, base_n[3:0], 7'h00, link_ready};
  wire [31:0] cfg_word = {7'h00, cfg_alloc, 2'h0, cfg_out_bytes, 2'h0, cfg_in_bytes, 5'h00, cfg_station};
  wire [31:0] rd_mux = hit_user ? {16'h0000, user_in[wofs[4:2]]} :
                       hit_out ? {16'h0000, out_word[oofs[4:2]]} :
                       hit_cfg ? cfg_word :
                       hit_sts ? sts_word :
                       hit_isr ? {29'h0, irq_sts} :
                       hit_ien ? {29'h0, irq_en} : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      rd_q <= pwrite ? 32'h0000_0000 : rd_mux;
      err_q <= !mapped;
    end
  end
  assign prdata = rd_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_q;

  // ***********************
  // checks
  // ***********************
  // in_run mirrors the sequencer so the checks read like the rules
  wire in_run = state == FRIO_RUN;
  ready_after_init_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == FRIO_INIT && init_cnt == 16'(INIT_CYC - 1) && !apply |=> link_ready && in_run)
    else $error("link ready not raised after init count");
  restart_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    apply |=> !link_ready ##1 !link_ready)
    else $error("apply did not restart the block");
  ready_point_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 remote_in_point[`FRIO_LINK_READY_BIT] == $past(link_ready))
    else $error("link ready point does not follow the flag");
  base_index_a: assert property (@(posedge pclk) disable iff (!presetn)
    link_req.req && in_run && link_req.word == 8'((act_station - 3'h1) * 2) |=> link_rsp.hit)
    else $error("base word of the station not accepted");
  range_miss_a: assert property (@(posedge pclk) disable iff (!presetn)
    link_take && link_req.word >= base_n + 8'(WORDS) |=> link_rsp.ack && !link_rsp.hit)
    else $error("word beyond six-word range accepted");
  status_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    act_alloc && act_in_bytes >= 6'h04 && !apply |=> remote_in_point[15:0] == $past(robot_status[15:0]))
    else $error("status points out of order");
  no_alloc_a: assert property (@(posedge pclk) disable iff (!presetn)
    !act_alloc |=> remote_cmd == '0)
    else $error("commands decoded without allocation");
  cmd_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    act_alloc && !apply |=> remote_cmd.start == $past(out_word[0][0]) && remote_cmd.shutdown == $past(out_word[0][11]))
    else $error("command points misplaced");
  out_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    link_wr_hit && rel_word == 8'h00 && act_out_bytes >= 6'h02 && !apply |=> out_word[0] == $past(link_req.wdata))
    else $error("master word not stored");
  size_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    act_in_bytes == 6'h00 && !act_alloc |=> remote_in_point[15:0] == 16'h0000)
    else $error("points beyond configured size visible");
  sticky_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    link_wr_hit |=> irq_sts[`FRIO_IRQ_WRITE_BIT])
    else $error("write event lost");
  // link answer timing, configuration hold, station clamp and output mask
  refuse_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    link_req.req && !link_ready |=> !link_rsp.ack)
    else $error("link request answered before ready");
  ack_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 link_rsp.ack == $past(link_take))
    else $error("link answer not one cycle after request");
  cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !apply |=> act_in_bytes == $past(act_in_bytes) && act_alloc == $past(act_alloc))
    else $error("map changed without restart");
  station_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
    apply && (cfg_station == 3'h0 || cfg_station > 3'h4) |=> act_station == 3'h1)
    else $error("illegal station not clamped");
  out_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (out_flat & ~out_mask) == '0)
    else $error("master bits beyond output size stored");
  // interrupt status: an event in the clearing cycle must survive
  event_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (irq_sts & $past(irq_evt)) == $past(irq_evt))
    else $error("event lost in clearing cycle");
  cover_restart_c: cover property (@(posedge pclk) disable iff (!presetn) apply ##1 !link_ready);
  cover_read_c: cover property (@(posedge pclk) disable iff (!presetn) link_take && !link_req.we && link_hit);
  cover_alloc_c: cover property (@(posedge pclk) disable iff (!presetn) act_alloc && remote_cmd.start);
  cover_irq_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule
`default_nettype wire

// File: verif/frio_link_master.sv
// fieldbus master station model: word reads and writes on the link port
`timescale 1ns/10ps
`default_nettype none
module frio_link_master (
  // clock
  input wire logic pclk,
  // link
  output var frio_pkg::frio_link_req_t link_req,
  input wire frio_pkg::frio_link_rsp_t link_rsp
);
  import frio_pkg::*;
  // ***********************
  // word transfer
  // ***********************
  initial link_req = '0;
  // request is a one-cycle pulse; released data lines flip so stale data never passes
  task automatic xfer(input logic we, input logic [7:0] word, input logic [15:0] wdata,
                      output logic ack, output logic hit, output logic [15:0] rdata);
    begin
      ack = 1'b0;
      hit = 1'b0;
      rdata = 16'h0000;
      @(posedge pclk);
      link_req <= '{req: 1'b1, we: we, word: word, wdata: wdata};
      @(posedge pclk);
      link_req.req <= 1'b0;
      link_req.wdata <= ~wdata;
      for (int i = 0; i < 4 && ack !== 1'b1; i++) begin
        @(posedge pclk);
        if (link_rsp.ack === 1'b1) begin
          ack = 1'b1;
          hit = link_rsp.hit;
          rdata = link_rsp.rdata;
        end
      end
    end
  endtask
endmodule
`default_nettype wire

// File: verif/frio_map_bench.sv
// self-checking bench for the fieldbus remote point map
`timescale 1ns/10ps
`default_nettype none
`include "frio_consts.svh"
module frio_map_bench;
  import frio_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, link_ready, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic perr, ack, hit;
  logic [15:0] ld;
  logic [95:0] remote_in_point, remote_out_point;
  frio_robot_status_t robot_status;
  frio_remote_cmd_t remote_cmd;
  frio_link_req_t link_req;
  frio_link_rsp_t link_rsp;
  int err_count, cmp_count;
  // short init count keeps each restart cheap
  frio_map #(.WORDS(6), .INIT_CYC(8)) frio_map_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .robot_status(robot_status), .remote_cmd(remote_cmd), .link_req(link_req),
    .link_rsp(link_rsp), .remote_in_point(remote_in_point), .remote_out_point(remote_out_point),
    .link_ready(link_ready), .irq(irq));
  frio_link_master frio_link_master_inst (.pclk(pclk), .link_req(link_req), .link_rsp(link_rsp));
  // ***********************
  // helpers
  // ***********************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task chk(input logic [95:0] seen, input logic [95:0] exp, input string what);
    begin
      cmp_count++;
      if (seen !== exp) begin
        err_count++;
        $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
    end
  endtask
  // apb master: request held until pready sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (pready !== 1'b1 && n < 50);
      // a slave that never answers fails the run instead of passing silently
      if (pready !== 1'b1) begin
        err_count++;
        $display("Error at %0t: apb answer timeout", $time);
      end
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task lx(input logic we, input logic [7:0] word, input logic [15:0] d);
    frio_link_master_inst.xfer(we, word, d, ack, hit, ld);
  endtask
  task wait_ready;
    int n;
    begin
      n = 0;
      while (link_ready !== 1'b1 && n < 100) begin
        @(posedge pclk);
        n++;
      end
      chk(n < 100, 1, "ready wait");
      // the point image lags the flag by one edge
      @(posedge pclk);
    end
  endtask
  // new config only counts after apply, which restarts the block
  task apply(input logic [2:0] s, input logic [5:0] ib, input logic alloc);
    begin
      apb(1'b1, `FRIO_CONFIG_OFS, {7'h0, alloc, 2'h0, 6'h20, 2'h0, ib, 5'h0, s});
      apb(1'b1, `FRIO_CTRL_OFS, 32'h1);
      @(posedge pclk);
      chk(link_ready, 0, "restart");
      wait_ready;
    end
  endtask
  task users(input logic [15:0] a, input logic [15:0] b);
    begin
      apb(1'b1, `FRIO_USER_IN_OFS, {16'h0, a});
      for (int k = 1; k < 6; k++) begin
        apb(1'b1, 8'(`FRIO_USER_IN_OFS + 4 * k), {16'h0, b});
      end
      repeat (3) @(posedge pclk);
    end
  endtask
  // ***********************
  // scenarios
  // ***********************
  task t_init;
    begin
      chk(link_ready, 0, "ready early");
      lx(1'b0, 8'h05, 16'h0);
      chk(ack, 0, "early ack");
      wait_ready;
      chk(remote_in_point[91], 1, "ready point");
      apb(1'b0, `FRIO_CONFIG_OFS, 0);
      chk(rd, 32'h0020_2001, "config reset");
      $display("test init done");
    end
  endtask
  task t_station;
    logic [7:0] n;
    begin
      for (int s = 1; s <= 4; s++) begin
        apply(3'(s), 6'h20, 1'b0);
        n = 8'((s - 1) * 2);
        apb(1'b0, `FRIO_STATUS_OFS, 0);
        chk(rd[11:8], n[3:0], "base index");
        lx(1'b0, n + 8'h05, 16'h0);
        chk({ack, hit, ld[11]}, 3'b111, "top word");
        lx(1'b0, n + 8'h06, 16'h0);
        chk({ack, hit}, 2'b10, "past top");
        lx(1'b0, n - 8'h01, 16'h0);
        chk({ack, hit}, 2'b10, "below base");
      end
      // an illegal station number falls back to station 1
      apply(3'h6, 6'h20, 1'b0);
      apb(1'b0, `FRIO_STATUS_OFS, 0);
      chk(rd[11:8], 4'h0, "station fallback");
      $display("test station done");
    end
  endtask
  task t_alloc;
    begin
      apply(3'h1, 6'h20, 1'b0);
      robot_status <= 31'h2b5c_e1a7;
      users(16'hc3a5, 16'hd23c);
      chk(remote_in_point[31:0], 32'hd23c_c3a5, "unallocated");
      lx(1'b1, 8'h00, 16'h0a5b);
      repeat (2) @(posedge pclk);
      chk(remote_cmd, 0, "cmd blocked");
      chk(remote_out_point[15:0], 16'h0a5b, "out word");
      apply(3'h1, 6'h20, 1'b1);
      users(16'hc3a5, 16'hd23c);
      chk(remote_in_point[30:0], robot_status, "status map");
      chk({remote_in_point[91], remote_in_point[31]}, 2'b11, "free point");
      lx(1'b1, 8'h00, 16'h0a5b);
      repeat (2) @(posedge pclk);
      chk(remote_cmd, 12'ha5b, "cmd map");
      lx(1'b0, 8'h01, 16'h0);
      chk(ld, {1'b1, robot_status[30:16]}, "word one");
      $display("test alloc done");
    end
  endtask
  task t_size;
    begin
      lx(1'b1, 8'h03, 16'hbeef);
      apply(3'h1, 6'h02, 1'b0);
      apb(1'b0, `FRIO_STATUS_OFS, 0);
      chk(rd[25:16], 10'd527, "last bit");
      apb(1'b0, 8'(`FRIO_OUT_WORD_OFS + 12), 0);
      chk(rd, 0, "out cleared");
      users(16'hffff, 16'hffff);
      chk(remote_in_point, {80'h1 << 75, 16'hffff}, "size limit");
      // zero input bytes still leaves the fixed link ready point
      apply(3'h1, 6'h00, 1'b0);
      @(posedge pclk);
      chk(remote_in_point, 96'h1 << 91, "size zero");
      $display("test size done");
    end
  endtask
  // sticky status, write-one clear, enable mask, unmapped address
  task t_irq;
    begin
      apply(3'h1, 6'h20, 1'b0);
      apb(1'b1, `FRIO_IRQ_CLEAR_OFS, 32'h7);
      apb(1'b1, `FRIO_IRQ_ENABLE_OFS, 32'h2);
      chk(irq, 0, "irq idle");
      lx(1'b1, 8'h02, 16'h1234);
      @(posedge pclk);
      chk(irq, 1, "irq raise");
      apb(1'b0, 8'(`FRIO_OUT_WORD_OFS + 8), 0);
      chk(rd, 32'h1234, "out read");
      apb(1'b1, `FRIO_IRQ_CLEAR_OFS, 32'h2);
      @(posedge pclk);
      chk(irq, 0, "irq clear");
      apb(1'b1, `FRIO_IRQ_ENABLE_OFS, 32'h4);
      lx(1'b1, 8'h02, 16'h0001);
      @(posedge pclk);
      chk(irq, 0, "irq masked");
      apb(1'b0, `FRIO_IRQ_STATUS_OFS, 0);
      chk(rd[2:0], 3'b010, "irq status");
      apb(1'b0, 8'h18, 0);
      chk(perr, 1, "unmapped");
      $display("test irq done");
    end
  endtask
  // ***********************
  // run control
  // ***********************
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    robot_status = '0;
    err_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_init;
    t_station;
    t_alloc;
    t_size;
    t_irq;
    print_verdict;
  end
endmodule
`default_nettype wire
